// File: rtl/slb_link_bringup.sv
// Purpose: out-of-band bring-up and speed negotiation, device end
// Assumes: rx_burst is the squelch level, rx_prim decoded per dword
// Notes:   calibration is skipped; tx speed code 3 is the fastest
`timescale 1ns/1ns
`default_nettype none
`include "slb_defines.svh"

module slb_link_bringup
(
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    // receive side
    input  wire logic             rx_burst,
    input  wire slb_pkg::slb_rx_t rx_prim,
    // local request
    input  wire logic             init_req,
    // transmit side and status
    output slb_pkg::slb_tx_t      tx_ff,
    output logic                  link_up_ff,
    output logic                  error_ff
);
    typedef enum {
        ST_SEND_INIT,
        ST_WAIT_WAKE,
        ST_SEND_WAKE,
        ST_ALIGN,
        ST_SYNC,
        ST_UP,
        ST_ERROR
    } slb_state_t;

    slb_state_t       state_ff;
    logic             rx_burst_d_ff;
    logic [6:0]       gap_ff;
    logic [2:0]       rst_gaps_ff;
    logic [2:0]       wake_gaps_ff;
    logic             reset_rel_ff;
    logic             wake_rel_ff;
    logic [3:0]       dw_acc_ff;
    logic             dw_tick_ff;
    logic [11:0]      dw_cnt_ff;
    logic             dw_wrap;
    logic [1:0]       speed_ff;
    logic [1:0]       run_ff;
    logic             gen_start_ff;
    slb_pkg::slb_oob_t gen_kind_ff;
    logic             gen_burst;
    logic             gen_busy;
    logic             gen_done;
    slb_pkg::slb_tx_t nxt_tx;
    logic             is_align;
    logic             is_other;

    function automatic logic in_range(input logic [6:0] v,
                                      input logic [6:0] lo,
                                      input logic [6:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction

    assign is_align = rx_prim.valid && (rx_prim.kind == slb_pkg::PRIM_ALIGN);
    assign is_other = rx_prim.valid && (rx_prim.kind != slb_pkg::PRIM_ALIGN);
    assign dw_wrap  = dw_tick_ff && (dw_cnt_ff == `SLB_SPEED_TMO_DW - 12'h001);

    slb_oob_gen u_oob_gen
    (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .start    (gen_start_ff),
        .kind     (gen_kind_ff),
        .burst_ff (gen_burst),
        .busy_ff  (gen_busy),
        .done_ff  (gen_done)
    );

    // burst-sequence detector; gaps measured falling edge to rising edge
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_burst_d_ff <= 1'b0;
            gap_ff        <= 7'h00;
            rst_gaps_ff   <= 3'h0;
            wake_gaps_ff  <= 3'h0;
            reset_rel_ff  <= 1'b0;
            wake_rel_ff   <= 1'b0;
        end
        else
        begin
            rx_burst_d_ff <= rx_burst;
            reset_rel_ff  <= 1'b0;
            wake_rel_ff   <= 1'b0;
            if (rx_burst)
                gap_ff <= 7'h00;
            else if (gap_ff != 7'h7F)
                gap_ff <= gap_ff + 7'h01;
            if (rx_burst && !rx_burst_d_ff)
            begin
                // out-of-window spacing throws the sequence away
                if (in_range(gap_ff, 7'(`SLB_DET_MIN_CYC),
                             7'(`SLB_DET_MAX_CYC)))
                begin
                    if (rst_gaps_ff != 3'h7)
                        rst_gaps_ff <= rst_gaps_ff + 3'h1;
                    wake_gaps_ff <= 3'h0;
                end
                else if (in_range(gap_ff, 7'(`SLB_WAKE_MIN_CYC),
                                  7'(`SLB_DET_MIN_CYC - 1)))
                begin
                    if (wake_gaps_ff != 3'h7)
                        wake_gaps_ff <= wake_gaps_ff + 3'h1;
                    rst_gaps_ff <= 3'h0;
                end
                else
                begin
                    rst_gaps_ff  <= 3'h0;
                    wake_gaps_ff <= 3'h0;
                end
            end
            else if (!rx_burst &&
                     gap_ff == 7'(`SLB_DET_MAX_CYC + 1))
            begin
                // release: line idle past the longest legal gap
                reset_rel_ff <= (rst_gaps_ff >= `SLB_DET_GAPS);
                wake_rel_ff  <= (wake_gaps_ff >= `SLB_DET_GAPS);
                rst_gaps_ff  <= 3'h0;
                wake_gaps_ff <= 3'h0;
            end
        end
    end

    // gen1 dword tick from the local clock, 3 per 10 cycles
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dw_acc_ff  <= 4'h0;
            dw_tick_ff <= 1'b0;
        end
        else if (state_ff != ST_ALIGN || dw_wrap)
        begin
            // phase restarts with each try, so no step comes early
            dw_acc_ff  <= 4'h0;
            dw_tick_ff <= 1'b0;
        end
        else if (dw_acc_ff + `SLB_DW_ACC_STEP >= `SLB_DW_ACC_WRAP)
        begin
            dw_acc_ff  <= dw_acc_ff + `SLB_DW_ACC_STEP - `SLB_DW_ACC_WRAP;
            dw_tick_ff <= 1'b1;
        end
        else
        begin
            dw_acc_ff  <= dw_acc_ff + `SLB_DW_ACC_STEP;
            dw_tick_ff <= 1'b0;
        end
    end

    // sequencer; a line reset overrides any state, a line wake only ST_WAIT_WAKE and ST_ERROR
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff     <= ST_SEND_INIT;
            gen_start_ff <= 1'b0;
            gen_kind_ff  <= slb_pkg::OOB_INIT;
            speed_ff     <= `SLB_SPEED_GEN3;
            dw_cnt_ff    <= 12'h000;
            run_ff       <= 2'h0;
        end
        else
        begin
            gen_start_ff <= 1'b0;
            if (reset_rel_ff || init_req)
            begin
                // line reset and local request share this entry
                state_ff  <= ST_SEND_INIT;
                speed_ff  <= `SLB_SPEED_GEN3;
                dw_cnt_ff <= 12'h000;
            end
            else if (wake_rel_ff &&
                     (state_ff == ST_WAIT_WAKE || state_ff == ST_ERROR))
            begin
                state_ff     <= ST_SEND_WAKE;
                gen_start_ff <= !gen_busy;
                // a busy generator keeps its kind, so its done is not
                // taken for the end of our wake
                if (!gen_busy)
                    gen_kind_ff <= slb_pkg::OOB_WAKE;
                speed_ff     <= `SLB_SPEED_GEN3;
            end
            else
            begin
                case (state_ff)
                    ST_SEND_INIT:
                    begin
                        // no host prompt needed after reset
                        if (!gen_busy && !gen_start_ff)
                        begin
                            gen_start_ff <= 1'b1;
                            gen_kind_ff  <= slb_pkg::OOB_INIT;
                            state_ff     <= ST_WAIT_WAKE;
                        end
                    end
                    ST_WAIT_WAKE:
                        ;
                    ST_SEND_WAKE:
                    begin
                        if (!gen_busy && !gen_start_ff &&
                            gen_kind_ff != slb_pkg::OOB_WAKE)
                            gen_start_ff <= 1'b1;
                        if (gen_done && gen_kind_ff == slb_pkg::OOB_WAKE)
                        begin
                            state_ff  <= ST_ALIGN;
                            dw_cnt_ff <= 12'h000;
                        end
                        else if (!gen_busy && !gen_start_ff)
                            gen_kind_ff <= slb_pkg::OOB_WAKE;
                    end
                    ST_ALIGN:
                    begin
                        if (is_align)
                        begin
                            state_ff <= ST_SYNC;
                            run_ff   <= 2'h0;
                        end
                        else if (dw_tick_ff)
                        begin
                            if (dw_wrap)
                            begin
                                dw_cnt_ff <= 12'h000;
                                if (speed_ff == `SLB_SPEED_GEN1)
                                    state_ff <= ST_ERROR;
                                else
                                    speed_ff <= speed_ff - 2'h1;
                            end
                            else
                                dw_cnt_ff <= dw_cnt_ff + 12'h001;
                        end
                    end
                    ST_SYNC:
                    begin
                        if (is_align)
                            run_ff <= 2'h0;
                        else if (is_other)
                        begin
                            if (run_ff == `SLB_NONALIGN_RUN - 2'h1)
                                state_ff <= ST_UP;
                            else
                                run_ff <= run_ff + 2'h1;
                        end
                    end
                    ST_UP:
                        ;
                    ST_ERROR:
                        ;
                    default:
                        state_ff <= ST_SEND_INIT;
                endcase
            end
        end
    end

    // transmit selection
    always_comb
    begin
        nxt_tx.burst = gen_burst;
        nxt_tx.speed = speed_ff;
        case (state_ff)
            ST_ALIGN: nxt_tx.prim = slb_pkg::PRIM_ALIGN;
            ST_SYNC:  nxt_tx.prim = slb_pkg::PRIM_SYNC;
            ST_UP:    nxt_tx.prim = slb_pkg::PRIM_SYNC;
            default:  nxt_tx.prim = slb_pkg::PRIM_NONE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_ff      <= '0;
            link_up_ff <= 1'b0;
            error_ff   <= 1'b0;
        end
        else
        begin
            tx_ff      <= nxt_tx;
            link_up_ff <= (state_ff == ST_UP);
            error_ff   <= (state_ff == ST_ERROR);
        end
    end
endmodule // slb_link_bringup

`default_nettype wire

// File: rtl/slb_defines.svh
// Purpose: timing counts and codes for the serial link bring-up sequencer
// Assumes: 125 MHz reference clock, one cycle is 8000 ps
// Notes:   every cycle count is derived from a time in picoseconds
`ifndef SLB_DEFINES_SVH
`define SLB_DEFINES_SVH

`define SLB_CLK_PS          8000
// oob burst and gap times, ps
`define SLB_BURST_PS        106700
`define SLB_INIT_GAP_PS     320000
`define SLB_WAKE_GAP_PS     106700
`define SLB_DET_MIN_PS      175000
`define SLB_DET_MAX_PS      525000
`define SLB_WAKE_MIN_PS     35000
// least times round up, longest times round down
`define SLB_BURST_CYC    ((`SLB_BURST_PS + `SLB_CLK_PS - 1) / `SLB_CLK_PS)
`define SLB_INIT_GAP_CYC ((`SLB_INIT_GAP_PS + `SLB_CLK_PS - 1) / `SLB_CLK_PS)
`define SLB_WAKE_GAP_CYC ((`SLB_WAKE_GAP_PS + `SLB_CLK_PS - 1) / `SLB_CLK_PS)
`define SLB_DET_MIN_CYC  ((`SLB_DET_MIN_PS + `SLB_CLK_PS - 1) / `SLB_CLK_PS)
`define SLB_DET_MAX_CYC  (`SLB_DET_MAX_PS / `SLB_CLK_PS)
`define SLB_TAIL_CYC     (`SLB_DET_MAX_CYC + 1)
`define SLB_WAKE_MIN_CYC ((`SLB_WAKE_MIN_PS + `SLB_CLK_PS - 1) / `SLB_CLK_PS)
// gen1 dword is 80/3 ns: three dword ticks every ten clocks
`define SLB_DW_ACC_STEP     4'h3
`define SLB_DW_ACC_WRAP     4'hA
`define SLB_SPEED_TMO_DW    12'h800
`define SLB_OOB_BURSTS      3'h6
`define SLB_DET_GAPS        3'h3
`define SLB_NONALIGN_RUN    2'h3
// speed codes on the transmit side
`define SLB_SPEED_GEN1      2'h1
`define SLB_SPEED_GEN3      2'h3

`endif

// File: rtl/slb_pkg.sv
// Purpose: types shared by the link bring-up sequencer
// Assumes: primitives arrive already decoded by the receive path
// Notes:   none
package slb_pkg;
    typedef enum logic [1:0] {
        PRIM_NONE,
        PRIM_ALIGN,
        PRIM_SYNC,
        PRIM_OTHER
    } slb_prim_t;

    typedef struct packed {
        logic      valid;
        slb_prim_t kind;
    } slb_rx_t;

    typedef struct packed {
        logic       burst;
        slb_prim_t  prim;
        logic [1:0] speed;
    } slb_tx_t;

    typedef enum logic {
        OOB_INIT,
        OOB_WAKE
    } slb_oob_t;
endpackage

// File: rtl/slb_oob_gen.sv
// Purpose: six-burst out-of-band signal generator
// Assumes: start is a one-cycle pulse taken only while not busy
// Notes:   the line is held idle past the detector limit after the last burst
`timescale 1ns/1ns
`default_nettype none
`include "slb_defines.svh"

module slb_oob_gen
(
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    // request
    input  wire logic             start,
    input  wire slb_pkg::slb_oob_t kind,
    // line and status
    output logic                  burst_ff,
    output logic                  busy_ff,
    output logic                  done_ff
);
    logic [6:0]        tmr_ff;
    logic [2:0]        cnt_ff;
    slb_pkg::slb_oob_t kind_ff;
    logic [6:0]        gap_cyc;

    assign gap_cyc = (kind_ff == slb_pkg::OOB_WAKE) ?
                     7'(`SLB_WAKE_GAP_CYC) : 7'(`SLB_INIT_GAP_CYC);

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            burst_ff <= 1'b0;
            busy_ff  <= 1'b0;
            done_ff  <= 1'b0;
            tmr_ff   <= 7'h00;
            cnt_ff   <= 3'h0;
            kind_ff  <= slb_pkg::OOB_INIT;
        end
        else
        begin
            done_ff <= 1'b0;
            if (!busy_ff)
            begin
                if (start)
                begin
                    busy_ff  <= 1'b1;
                    burst_ff <= 1'b1;
                    kind_ff  <= kind;
                    tmr_ff   <= 7'h00;
                    cnt_ff   <= 3'h1;
                end
            end
            else if (burst_ff)
            begin
                // each burst 160 oob unit intervals
                if (tmr_ff == 7'(`SLB_BURST_CYC - 1))
                begin
                    burst_ff <= 1'b0;
                    tmr_ff   <= 7'h00;
                end
                else
                    tmr_ff <= tmr_ff + 7'h01;
            end
            else if (cnt_ff != `SLB_OOB_BURSTS)
            begin
                if (tmr_ff == gap_cyc - 7'h01)
                begin
                    burst_ff <= 1'b1;
                    tmr_ff   <= 7'h00;
                    cnt_ff   <= cnt_ff + 3'h1;
                end
                else
                    tmr_ff <= tmr_ff + 7'h01;
            end
            else if (tmr_ff == 7'(`SLB_TAIL_CYC - 1))
            begin
                busy_ff <= 1'b0;
                done_ff <= 1'b1;
            end
            else
                tmr_ff <= tmr_ff + 7'h01;
        end
    end
endmodule // slb_oob_gen

`default_nettype wire

// File: tb/slb_link_bringup_checker.sv
// Purpose: port assertions for the link bring-up sequencer
// Assumes: one clock domain, async active-low reset
// Notes:   burst and gap figures are ref_clk cycles
`timescale 1ns/1ns
`default_nettype none

module slb_link_bringup_checker
(
    // clock and reset
    input wire logic             ref_clk,
    input wire logic             rst_n,
    // observed ports
    input wire logic             rx_burst,
    input wire slb_pkg::slb_rx_t rx_prim,
    input wire logic             init_req,
    input wire slb_pkg::slb_tx_t tx_ff,
    input wire logic             link_up_ff,
    input wire logic             error_ff
);
    logic [4:0]  hi_ff;
    logic [6:0]  lo_ff;
    logic [2:0]  bcnt_ff;
    logic        seen_ff;
    logic [12:0] stay_ff;
    logic [1:0]  spd_ff;
    logic        al_ff;
    logic [1:0]  nal_ff;
    wire         is_al = tx_ff.prim == slb_pkg::PRIM_ALIGN;
    wire         rx_al = rx_prim.kind == slb_pkg::PRIM_ALIGN;

    // burst shape: high run, low run, bursts per set
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hi_ff   <= 5'h00;
            lo_ff   <= 7'h00;
            bcnt_ff <= 3'h0;
            seen_ff <= 1'b0;
        end
        else
        begin
            hi_ff <= tx_ff.burst ? hi_ff + 5'h01 : 5'h00;
            lo_ff <= tx_ff.burst ? 7'h00 : lo_ff + 7'(lo_ff != 7'h7F);
            if (tx_ff.burst && hi_ff == 5'h00)
            begin
                bcnt_ff <= (lo_ff >= 7'h42 || !seen_ff) ? 3'h1
                                                        : bcnt_ff + 3'h1;
                seen_ff <= 1'b1;
            end
        end
    end

    // time spent streaming ALIGN at one speed; held outside ALIGN
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stay_ff <= 13'h0000;
            spd_ff  <= 2'h0;
            al_ff   <= 1'b0;
        end
        else
        begin
            al_ff <= is_al;
            if (is_al)
            begin
                spd_ff  <= tx_ff.speed;
                stay_ff <= (al_ff && tx_ff.speed == spd_ff) ?
                           stay_ff + 13'h0001 : 13'h0000;
            end
        end
    end

    // back-to-back non-ALIGN primitives received
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            nal_ff <= 2'h0;
        else if (rx_prim.valid)
            nal_ff <= rx_al ? 2'h0 : nal_ff + 2'(nal_ff != 2'h3);
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    AST_BURST_LEN: assert property (
        $fell(tx_ff.burst) |-> hi_ff == 5'h0E)
        else $error("device burst is not 14 cycles");
    AST_GAP: assert property (
        tx_ff.burst && hi_ff == 5'h00 && seen_ff |->
        lo_ff inside {7'h0E, 7'h28} || lo_ff >= 7'h42)
        else $error("device burst gap out of shape");
    AST_SIX: assert property (
        !tx_ff.burst && lo_ff == 7'h42 && seen_ff |-> bcnt_ff == 3'h6)
        else $error("burst set is not six bursts");
    AST_ALIGN_START: assert property (
        is_al && !al_ff |-> tx_ff.speed == 2'h3 && !tx_ff.burst)
        else $error("ALIGN stream not started at top speed");
    AST_STEP_DOWN: assert property (
        is_al && al_ff && tx_ff.speed != spd_ff |->
        tx_ff.speed == spd_ff - 2'h1)
        else $error("speed did not step down by one");
    AST_STEP_TIME: assert property (
        is_al && al_ff && tx_ff.speed != spd_ff |->
        stay_ff inside {[13'd6824:13'd6832]})
        else $error("speed step not at 2048 dword times");
    AST_ERROR: assert property (
        $rose(error_ff) |-> spd_ff == 2'h1 && stay_ff >= 13'd6824)
        else $error("error state without full lowest speed try");
    AST_SYNC: assert property (
        rx_prim.valid && rx_al && is_al && !tx_ff.burst |->
        ##[1:3] tx_ff.prim == slb_pkg::PRIM_SYNC)
        else $error("no SYNC after host ALIGN");
    AST_LINK: assert property (
        $rose(link_up_ff) |-> nal_ff == 2'h3)
        else $error("link up without three non-ALIGN");
    AST_INIT: assert property (
        init_req && !tx_ff.burst && lo_ff == 7'h7F |-> ##[1:5] tx_ff.burst)
        else $error("no burst after local init request");

    cover property ($rose(link_up_ff));
    cover property ($rose(error_ff));
    cover property ($fell(rx_burst) && init_req);
endmodule // slb_link_bringup_checker

bind slb_link_bringup slb_link_bringup_checker u_chk
(
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .rx_burst   (rx_burst),
    .rx_prim    (rx_prim),
    .init_req   (init_req),
    .tx_ff      (tx_ff),
    .link_up_ff (link_up_ff),
    .error_ff   (error_ff)
);

`default_nettype wire

// File: tb/slb_host_model.sv
// Purpose: behavioural host end for link bring-up tests
// Assumes: bench calls its tasks at the falling edge
// Notes:   squelch idles low; lock not modelled, restart window only flagged
`timescale 1ns/1ns
`default_nettype none

module slb_host_model
(
    // clock
    input  wire logic             ref_clk,
    // line toward the device receiver
    output var logic              rx_burst,
    output var slb_pkg::slb_rx_t  rx_prim,
    // line from the device transmitter
    input  wire slb_pkg::slb_tx_t dev_tx
);
    // 32768 dword times at 3 dwords per 10 cycles
    localparam int ALIGN_WAIT_CYC = 109227;
    int cyc;
    int wake_at;
    int align_at;

    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (dev_tx.prim == slb_pkg::PRIM_ALIGN)
            align_at <= cyc;
    end

    // window after our wake ran out with no ALIGN: power-on restart due
    function automatic logic restart_due();
        return align_at < wake_at && cyc - wake_at >= ALIGN_WAIT_CYC;
    endfunction

    // D10.2 fill decodes to no primitive, so valid stays low
    initial
    begin
        rx_burst = 1'b0;
        cyc      = 0;
        wake_at  = 0;
        align_at = 0;
        rx_prim  = '{1'b0, slb_pkg::PRIM_OTHER};
    end

    // gap 40 is a reset, gap 14 a wake; line left idle afterwards
    task automatic oob(input int gap, input int n);
        for (int i = 0; i < n; i++)
        begin
            @(negedge ref_clk) rx_burst <= 1'b1;
            repeat (14) @(negedge ref_clk);
            rx_burst <= 1'b0;
            repeat (gap - 1) @(negedge ref_clk);
        end
        // wake-class spacing opens the first-ALIGN window
        if (gap < 22)
            wake_at = cyc;
    endtask

    // one primitive per dword; kind inverted while not valid
    task automatic prim(input slb_pkg::slb_prim_t k);
        @(negedge ref_clk) rx_prim <= '{1'b1, k};
        @(negedge ref_clk) rx_prim <= '{1'b0, slb_pkg::slb_prim_t'(~k)};
        repeat (2) @(negedge ref_clk);
    endtask
endmodule // slb_host_model

`default_nettype wire

// File: tb/slb_link_bringup_bench.sv
// Purpose: directed tests of the link bring-up sequencer
// Assumes: host end played by slb_host_model
// Notes:   speed timeouts run full length, about 21k cycles
`timescale 1ns/1ns
`default_nettype none

module slb_link_bringup_bench;
    logic             ref_clk;
    logic             rst_n;
    logic             init_req;
    logic             rx_burst;
    slb_pkg::slb_rx_t rx_prim;
    slb_pkg::slb_tx_t tx_ff;
    logic             link_up_ff;
    logic             error_ff;
    int               fails;
    int               check_count;

    slb_link_bringup dut
    (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .rx_burst   (rx_burst),
        .rx_prim    (rx_prim),
        .init_req   (init_req),
        .tx_ff      (tx_ff),
        .link_up_ff (link_up_ff),
        .error_ff   (error_ff)
    );

    slb_host_model host
    (
        .ref_clk  (ref_clk),
        .rx_burst (rx_burst),
        .rx_prim  (rx_prim),
        .dev_tx   (tx_ff)
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // gap runs also end when a primitive stream starts
    task automatic run(input logic lvl, output int n);
        n = 0;
        while (tx_ff.burst === lvl && n < 200 &&
               (lvl || tx_ff.prim == slb_pkg::PRIM_NONE))
        begin
            @(negedge ref_clk);
            n++;
        end
    endtask

    // six device bursts of 14 cycles at the given gap, then idle
    task automatic dev_set(input int gap);
        int n;
        n = 0;
        while (tx_ff.burst !== 1'b1 && n < 3000)
        begin
            @(negedge ref_clk);
            n++;
        end
        chk(16'(n < 3000), 16'h0001);
        for (int i = 0; i < 6; i++)
        begin
            run(1'b1, n);
            chk(16'(n), 16'h000E);
            run(1'b0, n);
            chk(16'(i < 5 ? n : int'(n >= 66)), 16'(i < 5 ? gap : 1));
        end
    endtask

    // reset, wake, ALIGN lock, SYNC, link up; out-of-window spacing and a wake while up ignored
    task automatic test_full();
        slb_pkg::slb_prim_t seq[5] = '{slb_pkg::PRIM_OTHER,
            slb_pkg::PRIM_SYNC, slb_pkg::PRIM_ALIGN, slb_pkg::PRIM_OTHER,
            slb_pkg::PRIM_OTHER};
        host.oob(40, 6);
        dev_set(40);
        host.oob(14, 6);
        dev_set(14);
        chk(16'(tx_ff), 16'({1'b0, slb_pkg::PRIM_ALIGN, 2'h3}));
        repeat (100) @(negedge ref_clk);
        host.prim(slb_pkg::PRIM_ALIGN);
        chk(16'(tx_ff.prim), 16'(slb_pkg::PRIM_SYNC));
        foreach (seq[i])
            host.prim(seq[i]);
        chk(16'(link_up_ff), 16'h0000);
        host.prim(slb_pkg::PRIM_OTHER);
        chk(16'(link_up_ff), 16'h0001);
        host.oob(70, 6);
        host.oob(21, 6);
        repeat (100) @(negedge ref_clk);
        chk(16'({link_up_ff, tx_ff}), 16'h002B);
        $display("test_full done");
    endtask

    // no host ALIGN: timed steps 3, 2, 1, error, then a fresh wake
    task automatic test_speed();
        int n;
        @(negedge ref_clk) init_req = 1'b1;
        @(negedge ref_clk) init_req = 1'b0;
        dev_set(40);
        host.oob(14, 6);
        dev_set(14);
        chk(16'(host.restart_due()), 16'h0000);
        for (int s = 3; s > 0; s--)
        begin
            chk(16'(tx_ff.speed), 16'(s));
            n = 0;
            while (tx_ff.prim == slb_pkg::PRIM_ALIGN &&
                   tx_ff.speed == 2'(s) && n < 9000)
            begin
                @(negedge ref_clk);
                n++;
            end
            chk(16'(n >= 6825 && n <= 6833), 16'h0001);
        end
        repeat (2) @(negedge ref_clk);
        chk(16'({error_ff, tx_ff.prim}), 16'h0004);
        host.oob(14, 6);
        dev_set(14);
        chk(16'({error_ff, tx_ff.speed}), 16'h0003);
        $display("test_speed done");
    endtask

    initial
    begin
        rst_n = 1'b0;
        init_req = 1'b0;
        fails = 0;
        check_count = 0;
        repeat (4) @(negedge ref_clk);
        chk(16'({link_up_ff, error_ff, tx_ff}), 16'h0000);
        rst_n = 1'b1;
        dev_set(40);
        $display("test_cominit done");
        test_full();
        test_speed();
        report_and_stop();
    end

    // whole run needs about 25k cycles
    initial
    begin
        repeat (60000) @(posedge ref_clk);
        fails++;
        report_and_stop();
    end
endmodule // slb_link_bringup_bench

`default_nettype wire
